// ==== common/cog_pkg.sv ====
// constants, tables and types for the clock output and strap block
package cog_pkg;
   localparam int CLK_NS = 5;                 // system clock period
   localparam int STABLE_NS = 2_000_000;      // power-up stable time
   localparam int STABLE_CYC = STABLE_NS / CLK_NS;
   localparam int STRAP_CYC = 4;              // lets the pin filters settle
   localparam logic [6:0] SER_DEV_ADDR = 7'h69;   // serial slave address
   localparam int NREG = 6;
   localparam int REG_CTL = 0;                // spread, soft select
   localparam int REG_EN = 1;                 // per-output enables
   localparam int REG_PCI = 2;                // stoppable pci enables
   localparam int REG_MEM_L = 3;              // memory enables 7:0
   localparam int REG_MEM_H = 4;              // memory enables 12:8
   localparam int REG_TRI = 5;                // per-group tri-state
   localparam logic [7:0] REG_RST [NREG] = '{8'h00, 8'hFF, 8'h1F, 8'hFF, 8'h1F, 8'h00};
   // REG_EN bits
   localparam int EN_CPU_G = 0;
   localparam int EN_IRQ = 1;
   localparam int EN_PCI_F = 2;
   localparam int EN_REF_A = 3;
   localparam int EN_REF_B = 4;
   localparam int EN_24 = 5;
   localparam int EN_48 = 6;
   localparam int EN_CPU_F = 7;
   // REG_TRI bits
   localparam int TRI_CPU = 0;
   localparam int TRI_PCI = 1;
   localparam int TRI_MEM = 2;
   localparam int TRI_REF = 3;
   localparam int TRI_IRQ = 4;
   localparam int TRI_FIX = 5;
   // outputs are modelled at 1/OUT_SCALE of the real rate
   localparam int OUT_SCALE = 100;
   localparam logic [31:0] INC_K =
      32'((64'd1 << 32) / (64'(1_000_000 / CLK_NS) * 64'(OUT_SCALE)));
   localparam logic [31:0] REF_KHZ = 32'd14318;
   localparam logic [31:0] F24_KHZ = 32'd24000;
   localparam logic [31:0] F48_KHZ = 32'd48000;
   localparam logic [31:0] RAMP_STEP = 32'h0000_0100;
   localparam logic [39:0] SS_LO = 40'h19;     // 0.25 % in 0.01 %
   localparam logic [39:0] SS_HI = 40'h32;     // 0.5 % in 0.01 %
   localparam logic [39:0] SS_DEN = 40'h2710;  // 100 %
   localparam int NCH = 26;
   localparam int NMEM = 13;
   localparam int NPCI = 5;
   // cpu frequency in kHz and pci divider, indexed by select code
   localparam logic [17:0] FREQ16 [16] = '{124000, 75000, 83300, 66800, 103000,
      112000, 133000, 100300, 120000, 115000, 110000, 105000, 140000, 150000,
      124000, 133000};
   localparam logic [2:0] DIV16 [16] = '{3, 2, 2, 2, 3, 3, 3, 3, 3, 3, 3, 3,
      4, 4, 4, 4};
   localparam logic [17:0] FREQ8 [8] = '{50000, 75000, 83300, 66800, 103000,
      112000, 133000, 100200};
   localparam logic [2:0] DIV8 [8] = '{2, 2, 2, 2, 3, 3, 4, 3};
   typedef struct packed {
      logic mode;
      logic [3:0] fs;
   } cog_strap_s;
   typedef struct packed {
      logic ss_half;
      logic [2:0] ssel;
      logic sw_sel;
      logic [2:0] rsv;
   } cog_ctl_s;
   typedef enum {SER_IDLE, SER_ADDR, SER_CMD, SER_CNT, SER_WR, SER_RD} cog_ser_e;
endpackage

// ==== hw/cog_clock_gating.sv ====
// clock output synthesis, gating, power-up straps and serial control
// Contract
// - free cpu clock ignores the cpu stop pin
// - cpu stop low holds gated cpu, irq, memory
// - mode strap picks reference out or pci stop
// - mode pin then drives free pci clock
// - frequency straps latched once, pins become outputs
// - sixteen or eight selectable frequency pairs
// - cpu frequency slews smoothly without glitches
// - pci stop low holds five pci clocks when the mode strap picks pci stop
// - memory clocks copy the buffer input
// - reference and irq clocks run at 14.318 MHz
// - fixed 48 MHz and 24 MHz outputs
// - spread modulation depth 0.25 or 0.5 percent
// - serial port stops outputs, overrides frequency
// - registers enable outputs and set tri-state
// - clocks stable within 2 ms of power-up
// - serial slave allows register read back
// - gating waits pci rise then own fall
// - output runs only if enable and pin permit
// - address, dummy command, dummy count, data; all acked
// - control bit picks hardware or software select
module cog_clock_gating #(
   parameter int STABLE_LEN = cog_pkg::STABLE_CYC,
   parameter bit FOUR_BIT = 1'b1
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // strap and stop inputs of the shared pins
   input wire logic mode_strap_i,
   input wire logic freq_strap_3_i,
   input wire logic freq_strap_2_i,
   input wire logic freq_strap_1_i,
   input wire logic freq_strap_0_i,
   input wire logic pci_stop_n_i,
   input wire logic cpu_stop_n_i,
   input wire logic buf_in_i,
   // shared pin drivers
   output logic pci_clk_free_o,
   output logic pci_clk_free_oe,
   output logic [4:0] pci_clk_gated,
   output logic pci_clk0_oe,
   output logic ref_clk_a_o,
   output logic ref_clk_a_oe,
   output logic ref_clk_b_o,
   output logic ref_clk_b_oe,
   output logic clk_24m_o,
   output logic clk_24m_oe,
   output logic clk_48m_o,
   output logic clk_48m_oe,
   // dedicated clock outputs
   output logic cpu_clk_free,
   output logic cpu_clk_gated,
   output logic irq_ctrl_clk,
   output logic [12:0] mem_clk,
   output logic [5:0] grp_oe,
   // serial port
   input wire logic ser_clk_i,
   input wire logic ser_data_i,
   output logic ser_data_o,
   output logic ser_data_oe,
   // status
   output logic clk_stable,
   output cog_pkg::cog_strap_s straps
);
   import cog_pkg::*;

   // ---------------- pin synchronisers ----------------
   logic [9:0] pin_in;        // all asynchronous inputs
   logic [9:0] sy1_q;         // first stage, read only by sy2
   logic [9:0] sy2_q;
   logic [9:0] sy3_q;
   logic [9:0] lv_q;          // filtered level
   logic [9:0] lv_d;
   assign pin_in = {ser_clk_i, ser_data_i, buf_in_i, cpu_stop_n_i, pci_stop_n_i,
                    mode_strap_i, freq_strap_3_i, freq_strap_2_i, freq_strap_1_i,
                    freq_strap_0_i};
   // a level is accepted only when stage two and three agree
   assign lv_d = (sy2_q & sy3_q) | (lv_q & (sy2_q | sy3_q));

   // three-flop chain; pulled-up pins rest high
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sy1_q <= '1;
         sy2_q <= '1;
         sy3_q <= '1;
         lv_q <= '1;
      end else begin
         sy1_q <= pin_in;
         sy2_q <= sy1_q;
         sy3_q <= sy2_q;
         lv_q <= lv_d;
      end
   end

   // ---------------- straps and power-up timer ----------------
   logic [2:0] strap_cnt_q;   // settle counter
   logic strap_done_q;        // straps frozen
   cog_strap_s strap_q;
   logic [31:0] stab_cnt_q;
   logic stable_q;

   // straps are taken from filtered levels, never at the reset edge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         strap_cnt_q <= '0;
         strap_done_q <= 1'b0;
         strap_q <= '0;
      end else if (!strap_done_q) begin
         if (strap_cnt_q == 3'(STRAP_CYC)) begin
            strap_done_q <= 1'b1;
            strap_q.mode <= lv_q[4];
            strap_q.fs <= {lv_q[3] & FOUR_BIT, lv_q[2:0]};
         end else begin
            strap_cnt_q <= strap_cnt_q + 3'h1;
         end
      end
   end

   // stable flag after the power-up window
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stab_cnt_q <= '0;
         stable_q <= 1'b0;
      end else if (stab_cnt_q == 32'(STABLE_LEN - 1)) begin
         stable_q <= 1'b1;
      end else begin
         stab_cnt_q <= stab_cnt_q + 32'h1;
      end
   end

   // ---------------- control registers ----------------
   logic [7:0] regs_q [NREG];
   cog_ctl_s ctl;
   logic [7:0] en;            // per-output enables
   logic [7:0] tri_v;         // tri-state per group
   logic wr_en;
   assign ctl = regs_q[REG_CTL];
   assign en = regs_q[REG_EN];
   assign tri_v = regs_q[REG_TRI];

   // ---------------- frequency select and slew ----------------
   logic [3:0] sel;
   logic [3:0] sel_q;
   logic [17:0] freq;
   logic [2:0] div_q;
   logic [31:0] tgt;
   logic [31:0] cur_q;        // slewing increment
   logic [31:0] eff_q;        // after spread modulation
   logic [8:0] ss_cnt_q;
   logic [7:0] tri_wave;
   logic [39:0] dev_full;
   logic [39:0] dev_mod;
   assign sel = ctl.sw_sel ? {strap_q.fs[3], ctl.ssel} : strap_q.fs;
   // live select here, so the first nco step after the straps lands on the strapped rate
   assign freq = FOUR_BIT ? FREQ16[sel] : FREQ8[sel[2:0]];
   assign tgt = 32'(freq * INC_K);
   assign tri_wave = ss_cnt_q[8] ? ~ss_cnt_q[7:0] : ss_cnt_q[7:0];
   assign dev_full = (40'(cur_q) * (ctl.ss_half ? SS_HI : SS_LO)) / SS_DEN;
   assign dev_mod = (dev_full * 40'(tri_wave)) >> 8;

   // select and divider are registered so the table path stays short
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sel_q <= '0;
         div_q <= 3'h2;
      end else begin
         sel_q <= sel;
         div_q <= FOUR_BIT ? DIV16[sel_q] : DIV8[sel_q[2:0]];
      end
   end

   // the nco never jumps phase, so a bounded step per cycle keeps edges clean
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cur_q <= '0;
      end else if (!strap_done_q) begin
         cur_q <= '0;
      end else if (cur_q == '0) begin
         cur_q <= tgt;
      end else if (tgt > cur_q + RAMP_STEP) begin
         cur_q <= cur_q + RAMP_STEP;
      end else if (cur_q > tgt + RAMP_STEP) begin
         cur_q <= cur_q - RAMP_STEP;
      end else begin
         cur_q <= tgt;
      end
   end

   // triangle down-spread below the current rate
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ss_cnt_q <= '0;
         eff_q <= '0;
      end else begin
         ss_cnt_q <= ss_cnt_q + 9'h1;
         eff_q <= cur_q - dev_mod[31:0];
      end
   end

   // ---------------- oscillators ----------------
   logic [31:0] cpu_acc_q;
   logic [31:0] pci_acc_q;
   logic [31:0] ref_acc_q;
   logic [31:0] f24_acc_q;
   logic [31:0] f48_acc_q;
   logic [31:0] pci_inc;
   always_comb begin
      case (div_q)
         3'h2: pci_inc = eff_q >> 1;
         3'h4: pci_inc = eff_q >> 2;
         default: pci_inc = eff_q / 32'h3;
      endcase
   end

   // phase accumulators; msb is the raw clock
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cpu_acc_q <= '0;
         pci_acc_q <= '0;
         ref_acc_q <= '0;
         f24_acc_q <= '0;
         f48_acc_q <= '0;
      end else begin
         cpu_acc_q <= cpu_acc_q + eff_q;
         pci_acc_q <= pci_acc_q + pci_inc;
         ref_acc_q <= ref_acc_q + 32'(REF_KHZ * INC_K);
         f24_acc_q <= f24_acc_q + 32'(F24_KHZ * INC_K);
         f48_acc_q <= f48_acc_q + 32'(F48_KHZ * INC_K);
      end
   end

   // ---------------- glitch-free gating ----------------
   logic cpu_ok;              // cpu stop released
   logic pci_ok;              // pci stop released or not in use
   logic [NCH-1:0] raw;
   logic [NCH-1:0] raw_p_q;
   logic [NCH-1:0] fall;
   logic [NCH-1:0] perm;
   logic [NCH-1:0] gate_v;
   logic [NCH-1:0] arm_v;
   logic [NCH-1:0] out_v;
   logic pci_rise;
   assign cpu_ok = lv_q[6];
   assign pci_ok = strap_q.mode | lv_q[5];
   assign raw = {{NMEM{lv_q[7]}}, {NPCI{pci_acc_q[31]}}, f48_acc_q[31],
                 f24_acc_q[31], ref_acc_q[31], ref_acc_q[31], pci_acc_q[31],
                 ref_acc_q[31], cpu_acc_q[31], cpu_acc_q[31]};
   assign perm = {{regs_q[REG_MEM_H][4:0], regs_q[REG_MEM_L]} & {NMEM{cpu_ok}},
                  regs_q[REG_PCI][4:0] & {NPCI{pci_ok}},
                  en[EN_48], en[EN_24], en[EN_REF_B], en[EN_REF_A], en[EN_PCI_F],
                  en[EN_IRQ] & cpu_ok, en[EN_CPU_G] & cpu_ok, en[EN_CPU_F]};
   assign fall = raw_p_q & ~raw;
   assign pci_rise = pci_acc_q[31] & ~raw_p_q[3];

   // previous raw levels for edge detection
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         raw_p_q <= '0;
      end else begin
         raw_p_q <= raw;
      end
   end

   // per channel: arm on a free pci rise, switch on the channel's own fall
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      logic arm_q;
      logic gate_q;
      logic o_q;
      assign gate_v[i] = gate_q;
      assign arm_v[i] = arm_q;
      assign out_v[i] = o_q;
      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            arm_q <= 1'b0;
            gate_q <= 1'b0;
            o_q <= 1'b0;
         end else begin
            if (arm_q && fall[i]) begin
               gate_q <= perm[i];
               arm_q <= 1'b0;
            end else if (pci_rise && perm[i] != gate_q) begin
               arm_q <= 1'b1;
            end
            o_q <= raw[i] & gate_q;
         end
      end
   end

   // ---------------- output enables ----------------
   logic [5:0] pin_oe_q;
   logic [5:0] grp_oe_q;
   logic sda_o_q;

   // shared pins stay inputs until the straps are frozen
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_oe_q <= '0;
         grp_oe_q <= '0;
         sda_o_q <= 1'b0;
      end else begin
         pin_oe_q[0] <= strap_done_q & ~tri_v[TRI_PCI];
         pin_oe_q[1] <= strap_done_q & ~tri_v[TRI_PCI];
         pin_oe_q[2] <= strap_done_q & strap_q.mode & ~tri_v[TRI_REF];
         pin_oe_q[3] <= strap_done_q & ~tri_v[TRI_REF];
         pin_oe_q[4] <= strap_done_q & ~tri_v[TRI_FIX];
         pin_oe_q[5] <= strap_done_q & ~tri_v[TRI_FIX];
         grp_oe_q <= ~tri_v[5:0];
         sda_o_q <= 1'b0;
      end
   end

   // ---------------- serial slave ----------------
   cog_ser_e st_q;
   logic [3:0] bitc_q;        // 8 marks the acknowledge slot
   logic [7:0] sr_q;
   logic [7:0] idx_q;
   logic sda_oe_q;
   logic [7:0] rd_byte;
   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;
   assign scl_rise = lv_d[9] & ~lv_q[9];
   assign scl_fall = ~lv_d[9] & lv_q[9];
   assign start_ev = lv_q[9] & lv_d[9] & lv_q[8] & ~lv_d[8];
   assign stop_ev = lv_q[9] & lv_d[9] & ~lv_q[8] & lv_d[8];
   assign rd_byte = (idx_q < 8'(NREG)) ? regs_q[idx_q[2:0]] : 8'h00;
   assign wr_en = scl_fall && bitc_q == 4'h8 && st_q == SER_WR && idx_q < 8'(NREG);

   // bits move on ser_clk rise, the line drive changes only on its fall and holds through the high phase
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= SER_IDLE;
         bitc_q <= '0;
         sr_q <= '0;
         idx_q <= '0;
         sda_oe_q <= 1'b0;
      end else if (start_ev) begin
         st_q <= SER_ADDR;
         bitc_q <= '0;
         idx_q <= '0;
         sda_oe_q <= 1'b0;
      end else if (stop_ev) begin
         st_q <= SER_IDLE;
         sda_oe_q <= 1'b0;
      end else if (st_q != SER_IDLE) begin
         if (scl_rise) begin
            if (bitc_q == 4'h8) begin
               bitc_q <= '0;
               if (st_q == SER_RD && lv_q[8]) begin
                  st_q <= SER_IDLE;                             // master nack ends read
               end
            end else begin
               sr_q <= {sr_q[6:0], lv_q[8]};
               bitc_q <= bitc_q + 4'h1;
            end
         end else if (scl_fall) begin
            if (bitc_q == 4'h8 && st_q == SER_RD) begin
               sda_oe_q <= 1'b0;                                // master acks
               idx_q <= idx_q + 8'h1;
            end else if (bitc_q == 4'h8) begin
               sda_oe_q <= 1'b1;
               case (st_q)
                  SER_ADDR: begin
                     if (sr_q[7:1] != SER_DEV_ADDR) begin
                        st_q <= SER_IDLE;                       // not ours
                        sda_oe_q <= 1'b0;
                     end else begin
                        st_q <= sr_q[0] ? SER_RD : SER_CMD;
                     end
                  end
                  SER_CMD: st_q <= SER_CNT;
                  SER_CNT: st_q <= SER_WR;
                  SER_WR: idx_q <= idx_q + 8'h1;
                  default: st_q <= SER_IDLE;
               endcase
            end else if (st_q == SER_RD) begin
               sda_oe_q <= ~rd_byte[~bitc_q[2:0]];
            end else begin
               sda_oe_q <= 1'b0;
            end
         end
      end
   end

   // register file; bytes past the map are acked and dropped
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int r = 0; r < NREG; r++) begin
            regs_q[r] <= REG_RST[r];
         end
      end else if (wr_en) begin
         regs_q[idx_q[2:0]] <= sr_q;
      end
   end

   // ---------------- port map ----------------
   assign cpu_clk_free = out_v[0];
   assign cpu_clk_gated = out_v[1];
   assign irq_ctrl_clk = out_v[2];
   assign pci_clk_free_o = out_v[3];
   assign ref_clk_a_o = out_v[4];
   assign ref_clk_b_o = out_v[5];
   assign clk_24m_o = out_v[6];
   assign clk_48m_o = out_v[7];
   assign pci_clk_gated = out_v[12:8];
   assign mem_clk = out_v[25:13];
   assign pci_clk_free_oe = pin_oe_q[0];
   assign pci_clk0_oe = pin_oe_q[1];
   assign ref_clk_a_oe = pin_oe_q[2];
   assign ref_clk_b_oe = pin_oe_q[3];
   assign clk_24m_oe = pin_oe_q[4];
   assign clk_48m_oe = pin_oe_q[5];
   assign grp_oe = grp_oe_q;
   assign ser_data_o = sda_o_q;
   assign ser_data_oe = sda_oe_q;
   assign clk_stable = stable_q;
   assign straps = strap_q;

   // ---------------- assertions ----------------
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_strap_hold:
   assert property (strap_done_q |=> strap_done_q && $stable(strap_q))
      else $error("straps changed after capture");
   a_ref_mode:
   assert property (strap_done_q && !strap_q.mode |=> ##1 !ref_clk_a_oe)
      else $error("reference pin driven in stop mode");
   a_soft_select:
   assert property (strap_done_q && ctl.sw_sel |=> sel_q == {strap_q.fs[3], $past(ctl.ssel)})
      else $error("software select not applied");
   a_hard_select:
   assert property (strap_done_q && !ctl.sw_sel |=> sel_q == strap_q.fs)
      else $error("strap select not applied");
   a_gate_on_fall:
   assert property ($changed(gate_v[1]) |-> $past(fall[1]) && $past(arm_v[1]))
      else $error("cpu gate switched off its falling edge");
   a_cpu_stop_low:
   assert property (!cpu_ok && !gate_v[1] |=> !cpu_clk_gated ##1 !cpu_clk_gated)
      else $error("gated cpu clock high while stopped");
   a_pci_stop_perm:
   assert property (!strap_q.mode && !lv_q[5] |-> perm[12:8] == 5'h00)
      else $error("pci clocks permitted while stopped");
   a_ramp_step:
   assert property ($past(cur_q) != 0 && $past(strap_done_q)
                    |-> cur_q <= $past(cur_q) + RAMP_STEP && $past(cur_q) <= cur_q + RAMP_STEP)
      else $error("cpu rate stepped too far");
   a_addr_ack:
   assert property (scl_fall && bitc_q == 4'h8 && st_q == SER_ADDR && sr_q[7:1] == SER_DEV_ADDR
                    |=> sda_oe_q)
      else $error("own address not acknowledged");
   a_free_pci_pin:
   assert property (strap_done_q && !tri_v[TRI_PCI] |=> pci_clk_free_oe)
      else $error("free pci pin not driven");

   c_reg_write: cover property (wr_en);
   c_read_back: cover property (st_q == SER_RD && scl_fall && bitc_q == 4'h8);
   c_cpu_stopped: cover property ($fell(gate_v[1]));
endmodule

// ==== test/clock_output_gating_straps_tb_top.sv ====
// self-checking bench for the clock output, gating and strap block
module clock_output_gating_straps_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import cog_pkg::*;
   localparam int STABLE_T = 50; // shortened power-up wait
   localparam int HB = 12; // serial half bit, well above the pin filter delay
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic cpu_stop_n_i = 1'b1;
   logic ser_clk_i = 1'b1;
   logic m_low = 1'b0; // master pulls the data line
   logic chip_stop_n = 1'b1; // chipset level on the pci stop pin
   cog_strap_s pull = 5'h1A;
   logic mode_strap_i, freq_strap_3_i, freq_strap_2_i, freq_strap_1_i, freq_strap_0_i;
   logic pci_stop_n_i, buf_in_i, ser_data_i, pci_clk_free_o, pci_clk_free_oe, pci_clk0_oe;
   logic ref_clk_a_o, ref_clk_a_oe, ref_clk_b_o, ref_clk_b_oe, clk_24m_o, clk_24m_oe;
   logic clk_48m_o, clk_48m_oe, cpu_clk_free, cpu_clk_gated, irq_ctrl_clk;
   logic ser_data_o, ser_data_oe, clk_stable, ack;
   logic [4:0] pci_clk_gated;
   logic [12:0] mem_clk;
   logic [5:0] grp_oe;
   logic [7:0] rd, prev;
   cog_strap_s straps;
   int num_errors = 0;
   int checks = 0;
   int cycles = 0;
   int rises [8];
   // rising edges seen on each watched clock
   wire [7:0] mon = {cpu_clk_free, cpu_clk_gated, irq_ctrl_clk, |mem_clk, pci_clk_free_o,
      |pci_clk_gated, ref_clk_a_o, clk_48m_o};
   cog_clock_gating #(.STABLE_LEN(STABLE_T), .FOUR_BIT(1'b1)) dut (.clk(clk), .reset_n(reset_n),
      .mode_strap_i(mode_strap_i), .freq_strap_3_i(freq_strap_3_i),
      .freq_strap_2_i(freq_strap_2_i), .freq_strap_1_i(freq_strap_1_i),
      .freq_strap_0_i(freq_strap_0_i), .pci_stop_n_i(pci_stop_n_i),
      .cpu_stop_n_i(cpu_stop_n_i), .buf_in_i(buf_in_i), .pci_clk_free_o(pci_clk_free_o),
      .pci_clk_free_oe(pci_clk_free_oe), .pci_clk_gated(pci_clk_gated),
      .pci_clk0_oe(pci_clk0_oe), .ref_clk_a_o(ref_clk_a_o), .ref_clk_a_oe(ref_clk_a_oe),
      .ref_clk_b_o(ref_clk_b_o), .ref_clk_b_oe(ref_clk_b_oe), .clk_24m_o(clk_24m_o),
      .clk_24m_oe(clk_24m_oe), .clk_48m_o(clk_48m_o), .clk_48m_oe(clk_48m_oe),
      .cpu_clk_free(cpu_clk_free), .cpu_clk_gated(cpu_clk_gated), .irq_ctrl_clk(irq_ctrl_clk),
      .mem_clk(mem_clk), .grp_oe(grp_oe), .ser_clk_i(ser_clk_i), .ser_data_i(ser_data_i),
      .ser_data_o(ser_data_o), .ser_data_oe(ser_data_oe), .clk_stable(clk_stable),
      .straps(straps));
   cog_board_model board (.pull(pull), .chip_stop_n(chip_stop_n), .master_low(m_low),
      .pci_clk_free_o(pci_clk_free_o), .pci_clk_free_oe(pci_clk_free_oe),
      .pci_clk0_o(pci_clk_gated[0]), .pci_clk0_oe(pci_clk0_oe), .ref_clk_a_o(ref_clk_a_o),
      .ref_clk_a_oe(ref_clk_a_oe), .ref_clk_b_o(ref_clk_b_o), .ref_clk_b_oe(ref_clk_b_oe),
      .clk_24m_o(clk_24m_o), .clk_24m_oe(clk_24m_oe), .clk_48m_o(clk_48m_o),
      .clk_48m_oe(clk_48m_oe), .cpu_clk_free(cpu_clk_free), .ser_data_oe(ser_data_oe),
      .mode_strap_i(mode_strap_i), .freq_strap_3_i(freq_strap_3_i),
      .freq_strap_2_i(freq_strap_2_i), .freq_strap_1_i(freq_strap_1_i),
      .freq_strap_0_i(freq_strap_0_i), .pci_stop_n_i(pci_stop_n_i), .buf_in_i(buf_in_i),
      .ser_data_i(ser_data_i));
   always #2.5 clk = ~clk;
   // edge counting and the hang limit; the whole run needs about 47000 cycles
   always @(posedge clk) begin
      prev <= mon;
      cycles <= cycles + 1;
      for (int i = 0; i < 8; i++)
         if (mon[i] && !prev[i]) rises[i] <= rises[i] + 1;
      if (cycles == 80000) begin
         num_errors++;
         final_report();
      end
   end
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge clk);
   endtask
   // clear the edge counts off the sampling edge, then watch n cycles
   task automatic window(int n);
      @(negedge clk);
      foreach (rises[i]) rises[i] = 0;
      tick(n);
   endtask
   // straps held from reset entry through the latch point
   task automatic powerup(logic [4:0] s);
      @(posedge clk);
      reset_n <= 1'b0;
      pull <= s;
      tick(8);
      reset_n <= 1'b1;
      tick(10);
   endtask
   // one serial bit: data moves only while the serial clock is low
   task automatic sbit(logic b, output logic r);
      m_low <= ~b;
      tick(HB);
      ser_clk_i <= 1'b1;
      tick(HB / 2);
      r = ser_data_i;
      tick(HB / 2);
      ser_clk_i <= 1'b0;
      tick(2);
   endtask
   // start: data falls while the clock is high; stop: data rises while it is high
   task automatic frame(logic stop_it);
      m_low <= stop_it;
      tick(HB);
      ser_clk_i <= 1'b1;
      tick(HB);
      m_low <= ~stop_it;
      tick(HB);
      if (!stop_it) ser_clk_i <= 1'b0;
      tick(2);
   endtask
   task automatic wbyte(logic [7:0] b, output logic a);
      logic r;
      for (int i = 7; i >= 0; i--) sbit(b[i], r);
      sbit(1'b1, r);
      a = ~r;
   endtask
   task automatic xfer(logic [7:0] q [$], logic [7:0] e [NREG]);
      frame(1'b0);
      foreach (q[i]) begin
         wbyte(q[i], ack);
         check("byte ack", 32'(ack), 32'(q[0] != 8'hA4));
      end
      for (int j = 0; j < NREG && q[0] == 8'hD3; j++) begin
         for (int i = 7; i >= 0; i--) sbit(1'b1, rd[i]);
         sbit(j == NREG - 1, ack);
         check("read back", 32'(rd), 32'(e[j]));
      end
      frame(1'b1);
   endtask
   task automatic final_report;
      if (num_errors == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      powerup(5'h1A);
      check("straps", 32'(straps), 32'h1A);
      check("ref pin drives", 32'({ref_clk_a_oe, pci_clk_free_oe}), 32'h3);
      check("early stable", 32'(clk_stable), 32'h0);
      for (int n = 0; n < STABLE_T && clk_stable !== 1'b1; n++) tick(1);
      check("stable", 32'(clk_stable), 32'h1);
      xfer('{8'hD3}, REG_RST);
      // cpu stop low, and the chipset pulls the pin that is a ref output now
      chip_stop_n <= 1'b0;
      cpu_stop_n_i <= 1'b0;
      tick(1500);
      window(3000);
      check("free cpu runs", 32'(rises[7] > 0), 32'h1);
      check("gated edges", 32'(rises[6] + rises[5] + rises[4]), 32'h0);
      check("gated level", 32'({cpu_clk_gated, irq_ctrl_clk, mem_clk}), 32'h0);
      check("pci in ref mode", 32'(rises[2] > 0), 32'h1);
      cpu_stop_n_i <= 1'b1;
      chip_stop_n <= 1'b1;
      tick(1500);
      window(3000);
      check("mem follows buffer", 32'(rises[4] inside {[rises[7]-1:rises[7]+1]}), 32'h1);
      check("ref rate", 32'(rises[1] inside {[2:3]}), 32'h1);
      check("48 rate", 32'(rises[0] inside {[7:8]}), 32'h1);
      check("strap cpu rate", 32'(rises[7] inside {[15:18]}), 32'h1);
      xfer('{8'hA4}, REG_RST);
      // free cpu clock stays enabled, the gated one is stopped by software
      xfer('{8'hD2, 8'h00, 8'h06, 8'h48, 8'hFE, 8'h1F, 8'hFF, 8'h1F, 8'h04}, REG_RST);
      xfer('{8'hD3}, '{8'h48, 8'hFE, 8'h1F, 8'hFF, 8'h1F, 8'h04});
      check("tri-state", 32'(grp_oe), 32'h3B);
      // the rate slews 256 per cycle, so the step to the soft rate takes ~25000 cycles
      tick(24000);
      window(3000);
      check("soft stop", 32'(rises[6]), 32'h0);
      check("soft cpu rate", 32'(rises[7] inside {[20:22]}), 32'h1);
      powerup(5'h03);
      check("relatched", 32'({straps, ref_clk_a_oe}), 32'h6);
      chip_stop_n <= 1'b0;
      tick(1500);
      window(3000);
      check("pci held", 32'({rises[2], 27'(pci_clk_gated)}), 32'h0);
      check("free pci runs", 32'(rises[3] > 0), 32'h1);
      final_report();
   end
endmodule

// ==== test/cog_board_model.sv ====
// board model around the clock block: strap pulls, chipset feeds and the serial line
module cog_board_model (
   // board pulls and chipset drives
   input wire cog_pkg::cog_strap_s pull,
   input wire logic chip_stop_n,
   input wire logic master_low,
   // device pin drivers
   input wire logic pci_clk_free_o,
   input wire logic pci_clk_free_oe,
   input wire logic pci_clk0_o,
   input wire logic pci_clk0_oe,
   input wire logic ref_clk_a_o,
   input wire logic ref_clk_a_oe,
   input wire logic ref_clk_b_o,
   input wire logic ref_clk_b_oe,
   input wire logic clk_24m_o,
   input wire logic clk_24m_oe,
   input wire logic clk_48m_o,
   input wire logic clk_48m_oe,
   input wire logic cpu_clk_free,
   input wire logic ser_data_oe,
   // pin levels seen by the device
   output logic mode_strap_i,
   output logic freq_strap_3_i,
   output logic freq_strap_2_i,
   output logic freq_strap_1_i,
   output logic freq_strap_0_i,
   output logic pci_stop_n_i,
   output logic buf_in_i,
   output logic ser_data_i
);
   import cog_pkg::*;
   // a released shared pin settles to its board pull, never to a stale level
   assign mode_strap_i = pci_clk_free_oe ? pci_clk_free_o : pull.mode;
   assign freq_strap_3_i = pci_clk0_oe ? pci_clk0_o : pull.fs[3];
   assign freq_strap_2_i = ref_clk_b_oe ? ref_clk_b_o : pull.fs[2];
   assign freq_strap_1_i = clk_24m_oe ? clk_24m_o : pull.fs[1];
   assign freq_strap_0_i = clk_48m_oe ? clk_48m_o : pull.fs[0];
   // chipset drives the stop pin, but loses to the device when it drives a clock
   assign pci_stop_n_i = ref_clk_a_oe ? ref_clk_a_o : chip_stop_n;
   // chipset returns the cpu clock into the memory fanout buffer
   assign buf_in_i = cpu_clk_free;
   // open-drain data line with pull-up: low while either side pulls
   assign ser_data_i = ~(master_low | ser_data_oe);
endmodule
